// File: hdl/ofd_top.v
// operand field decoder with state and axi4-lite registers
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ofd_defs.vh"
module ofd_top #(
    parameter BANK_W = 4,
    parameter PTR_W  = 21
) (
    // clock and reset
    input  wire              clk_i,
    input  wire              sys_rst_i,
    // axi4-lite slave
    input  wire [7:0]        s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    output wire [1:0]        s_axi_bresp,
    output wire              s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [7:0]        s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    output wire [31:0]       s_axi_rdata,
    output wire [1:0]        s_axi_rresp,
    output wire              s_axi_rvalid,
    input  wire              s_axi_rready,
    // instruction from fetch
    input  wire              instr_valid_i,
    input  wire [15:0]       instr_i,
    input  wire [15:0]       instr2_i,
    // datapath inputs
    input  wire [7:0]        alu_result_i,
    input  wire [7:0]        file_rdata_i,
    input  wire [7:0]        status_i,
    input  wire [11:0]       index_ptr_i,
    input  wire [7:0]        pm_rdata_i,
    // decoded fields
    output wire [11:0]       file_addr_o,
    output wire [7:0]        file8_o,
    output wire              dest_is_file_o,
    output wire              file_we_o,
    output wire              work_we_o,
    output wire [2:0]        bit_index_o,
    output wire [7:0]        bit_mask_o,
    output wire [1:0]        indirect_pointer_select_o,
    output wire [11:0]       src_addr_o,
    output wire [11:0]       dst_addr_o,
    output wire [7:0]        lit8_o,
    output wire [11:0]       lit12_o,
    output wire [19:0]       lit20_o,
    output wire              is_relative_o,
    output wire [20:0]       rel_offset_o,
    output wire [19:0]       direct_addr_o,
    output wire              fast_o,
    output wire              two_word_o,
    // table access
    output wire              pm_rd_o,
    output wire              pm_wr_o,
    output wire [PTR_W-1:0]  pm_addr_o,
    output wire [7:0]        pm_wdata_o,
    // fast return status restore
    output wire              status_restore_o,
    output wire [7:0]        status_shadow_o,
    // working state
    output wire [7:0]        working_register_o,
    output wire [BANK_W-1:0] bank_select_register_o,
    output wire [7:0]        product_high_byte_o,
    output wire [7:0]        product_low_byte_o
);
    // byte-lane merge for bus writes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    // opcode classes, only defined bits are looked at
    wire [3:0] op_hi     = instr_i[15:12];
    wire [7:0] op_byte   = instr_i[15:8];
    wire       is_bit    = (op_hi == 4'h7) || (op_hi[3:2] == 2'b10);
    wire       is_mulwf  = (instr_i[15:9] == 7'h01);
    wire       has_d     = ((op_hi >= 4'h1) && (op_hi <= 4'h5)) || (instr_i[15:10] == 6'h01);
    wire       is_byte   = has_d || (op_hi == 4'h6) || is_mulwf;
    wire       is_movff  = (op_hi == 4'hc);
    wire       is_lit8   = (instr_i[15:11] == 5'h01);
    wire       is_mullw  = (op_byte == 8'h0d);
    wire       is_lfsr   = (op_byte == 8'hee) && (instr_i[7:6] == 2'b00);
    wire       is_goto   = (op_byte == 8'hef);
    wire       is_call   = (instr_i[15:9] == 7'h76);
    wire       is_bra    = (instr_i[15:11] == 5'h1a) || (instr_i[15:11] == 5'h1b);
    wire       is_bcc    = (instr_i[15:11] == 5'h1c);
    wire       is_ret    = (instr_i[15:1] == 15'h0009) || (instr_i[15:1] == 15'h0008);
    wire       is_tbl    = (instr_i[15:3] == 13'h0001);
    wire       is_movsf  = (op_byte == 8'heb) && !instr_i[7];
    wire       is_movss  = (op_byte == 8'heb) && instr_i[7];
    wire       is_fast_s = is_call ? instr_i[8] : instr_i[0];

    // state registers
    reg  [BANK_W-1:0] bank_ff;
    reg  [7:0]        work_ff;
    reg  [7:0]        prod_hi_ff;
    reg  [7:0]        prod_lo_ff;
    reg  [3:0]        last_fmt_ff;
    wire [PTR_W-1:0]  tptr;
    wire [7:0]        tlat;
    wire [7:0]        sh_work;
    wire [BANK_W-1:0] sh_bank;

    // ram address from a, f and the bank register
    wire       acc_bit  = instr_i[`OFD_A_BIT];
    wire [7:0] f8       = instr_i[7:0];
    wire [3:0] acc_page = (f8 < `OFD_ACCESS_SPLIT) ? 4'h0 : 4'hf;
    wire [3:0] bank_pg  = bank_ff[3:0];
    assign file_addr_o    = acc_bit ? {bank_pg, f8} : {acc_page, f8};
    assign file8_o        = f8;
    assign dest_is_file_o = has_d && instr_i[`OFD_D_BIT];
    assign file_we_o      = instr_valid_i && dest_is_file_o;
    assign work_we_o      = instr_valid_i && has_d && !instr_i[`OFD_D_BIT];
    assign indirect_pointer_select_o = instr_i[5:4];

    // bit index and its one-hot mask
    assign bit_index_o = is_bit ? instr_i[`OFD_BIDX_HI:`OFD_BIDX_LO] : 3'h0;
    assign bit_mask_o  = 8'h01 << bit_index_o;

    // two-word moves, direct and indexed
    wire [11:0] idx_src = index_ptr_i + {5'h00, instr_i[6:0]};
    wire [11:0] idx_dst = index_ptr_i + {5'h00, instr2_i[6:0]}; // bits 11..7 ignored
    assign src_addr_o = is_movff ? instr_i[11:0] :
                        (is_movsf || is_movss) ? idx_src : file_addr_o;
    assign dst_addr_o = (is_movff || is_movsf) ? instr2_i[11:0] :
                        is_movss ? idx_dst : file_addr_o;
    assign two_word_o = is_movff || is_movsf || is_movss || is_lfsr || is_goto || is_call;

    // literal widths by format
    assign lit8_o  = instr_i[7:0];
    assign lit12_o = {instr_i[3:0], instr2_i[7:0]};
    assign lit20_o = {instr2_i[11:0], instr_i[7:0]};

    // signed offsets, direct targets
    assign is_relative_o = is_bra || is_bcc;
    assign rel_offset_o  = is_bra ? {{10{instr_i[10]}}, instr_i[10:0]} :
                           is_bcc ? {{13{instr_i[7]}}, instr_i[7:0]} : 21'h000000;
    assign direct_addr_o = lit20_o;
    assign fast_o        = (is_call || is_ret) && is_fast_s;

    // table access and latch
    wire tbl_go = instr_valid_i && is_tbl;
    assign pm_rd_o    = tbl_go && !instr_i[2];
    assign pm_wr_o    = tbl_go && instr_i[2];
    assign pm_wdata_o = tlat;

    // fast call saves, fast return restores
    wire fast_save    = instr_valid_i && is_call && instr_i[8];
    wire fast_restore = instr_valid_i && is_ret && instr_i[0];
    assign status_restore_o = fast_restore;

    ofd_shadow #(
        .BANK_W (BANK_W)
    ) u_shadow (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .save_i    (fast_save),
        .work_i    (work_ff),
        .status_i  (status_i),
        .bank_i    (bank_ff),
        .work_o    (sh_work),
        .status_o  (status_shadow_o),
        .bank_o    (sh_bank)
    );

    // axi write and read channel holding registers
    reg        aw_held_ff;
    reg        w_held_ff;
    reg [7:0]  awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0]  wstrb_ff;
    reg        bvalid_ff;
    reg [1:0]  bresp_ff;
    reg        rvalid_ff;
    reg [31:0] rdata_ff;
    reg [1:0]  rresp_ff;

    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready  = !w_held_ff && !bvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    wire        wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
    wire [31:0] wr_old  = (awaddr_ff == `OFD_REG_BANK) ? {28'h0000000, bank_pg} :
                          (awaddr_ff == `OFD_REG_WORK) ? {24'h000000, work_ff} :
                          (awaddr_ff == `OFD_REG_TPTR) ? {11'h000, tptr} :
                          {24'h000000, tlat};
    wire [31:0] wr_val  = merge(wr_old, wdata_ff, wstrb_ff);
    wire        wr_map  = (awaddr_ff == `OFD_REG_BANK) || (awaddr_ff == `OFD_REG_WORK) ||
                          (awaddr_ff == `OFD_REG_TPTR) || (awaddr_ff == `OFD_REG_TLAT);
    wire              sw_we_tptr = wr_fire && (awaddr_ff == `OFD_REG_TPTR);
    wire              sw_we_tlat = wr_fire && (awaddr_ff == `OFD_REG_TLAT);
    wire [PTR_W-1:0]  sw_tptr    = wr_val[PTR_W-1:0];
    wire [7:0]        sw_tlat    = wr_val[7:0];

    ofd_table_pointer #(
        .PTR_W (PTR_W),
        .LAT_W (8)
    ) u_table_pointer (
        .clk_i         (clk_i),
        .sys_rst_i     (sys_rst_i),
        .sw_ptr_we_i   (sw_we_tptr),
        .sw_lat_we_i   (sw_we_tlat),
        .sw_ptr_i      (sw_tptr),
        .sw_lat_i      (sw_tlat),
        .op_i          (tbl_go),
        .op_wr_i       (instr_i[2]),
        .mode_i        (instr_i[1:0]),
        .pm_rdata_i    (pm_rdata_i),
        .access_addr_o (pm_addr_o),
        .ptr_o         (tptr),
        .lat_o         (tlat)
    );

    // write address, data and response
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awaddr_ff  <= 8'h00;
            wdata_ff   <= 32'h00000000;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `OFD_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= wr_map ? `OFD_RESP_OKAY : `OFD_RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // read data, unmapped gives slverr
    wire [7:0] ar = {s_axi_araddr[7:2], 2'b00};
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h00000000;
            rresp_ff  <= `OFD_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= `OFD_RESP_OKAY;
            case (ar)
                `OFD_REG_BANK: rdata_ff <= {28'h0000000, bank_pg};
                `OFD_REG_WORK: rdata_ff <= {24'h000000, work_ff};
                `OFD_REG_TPTR: rdata_ff <= {11'h000, tptr};
                `OFD_REG_TLAT: rdata_ff <= {24'h000000, tlat};
                `OFD_REG_PROD: rdata_ff <= {16'h0000, prod_hi_ff, prod_lo_ff};
                `OFD_REG_STAT: rdata_ff <= {28'h0000000, last_fmt_ff};
                default: begin
                    rdata_ff <= 32'h00000000;
                    rresp_ff <= `OFD_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // 8x8 product split into two bytes
    wire [15:0] product = work_ff * (is_mullw ? lit8_o : file_rdata_i);

    // state; hardware beats software
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            work_ff     <= `OFD_RST_WORK;
            bank_ff     <= `OFD_RST_BANK;
            prod_hi_ff  <= 8'h00;
            prod_lo_ff  <= 8'h00;
            last_fmt_ff <= 4'h0;
        end else begin
            if (work_we_o) begin
                work_ff <= alu_result_i;
            end else if (fast_restore) begin
                work_ff <= sh_work;
            end else if (wr_fire && awaddr_ff == `OFD_REG_WORK) begin
                work_ff <= wr_val[7:0];
            end
            if (fast_restore) begin
                bank_ff <= sh_bank;
            end else if (wr_fire && awaddr_ff == `OFD_REG_BANK) begin
                bank_ff <= wr_val[BANK_W-1:0];
            end
            if (instr_valid_i && (is_mulwf || is_mullw)) begin
                prod_hi_ff <= product[15:8];
                prod_lo_ff <= product[7:0];
            end
            if (instr_valid_i) begin
                last_fmt_ff <= {is_movff || is_movsf || is_movss, is_bit, is_byte,
                                is_lit8 || is_lfsr};
            end
        end
    end

    // state seen by the datapath
    assign working_register_o     = work_ff;
    assign bank_select_register_o = bank_ff;
    assign product_high_byte_o    = prod_hi_ff;
    assign product_low_byte_o     = prod_lo_ff;
    // decode is combinational
endmodule
`default_nettype wire

// File: include/ofd_defs.vh
// constants and field layout for the operand field decoder
`ifndef OFD_DEFS_VH
`define OFD_DEFS_VH

// register byte offsets
`define OFD_REG_BANK      8'h00
`define OFD_REG_WORK      8'h04
`define OFD_REG_TPTR      8'h08
`define OFD_REG_TLAT      8'h0c
`define OFD_REG_PROD      8'h10
`define OFD_REG_STAT      8'h14

// reset values
`define OFD_RST_BANK      4'h0
`define OFD_RST_WORK      8'h00
`define OFD_RST_TPTR      21'h000000
`define OFD_RST_TLAT      8'h00

// field positions
`define OFD_D_BIT         9
`define OFD_A_BIT         8
`define OFD_BIDX_HI       11
`define OFD_BIDX_LO       9

// table update modes
`define OFD_TM_NONE       2'h0
`define OFD_TM_POSTINC    2'h1
`define OFD_TM_POSTDEC    2'h2
`define OFD_TM_PREINC     2'h3

// access region split
`define OFD_ACCESS_SPLIT  8'h60

// bus responses
`define OFD_RESP_OKAY     2'h0
`define OFD_RESP_SLVERR   2'h2

`endif

// File: hdl/ofd_table_pointer.v
// table pointer and table latch with the four update modes
`timescale 1ns/1ps
`default_nettype none
`include "ofd_defs.vh"
module ofd_table_pointer #(
    parameter PTR_W = 21,
    parameter LAT_W = 8
) (
    // clock and reset
    input  wire             clk_i,
    input  wire             sys_rst_i,
    // software access
    input  wire             sw_ptr_we_i,
    input  wire             sw_lat_we_i,
    input  wire [PTR_W-1:0] sw_ptr_i,
    input  wire [LAT_W-1:0] sw_lat_i,
    // table operation
    input  wire             op_i,
    input  wire             op_wr_i,
    input  wire [1:0]       mode_i,
    input  wire [LAT_W-1:0] pm_rdata_i,
    // state out
    output wire [PTR_W-1:0] access_addr_o,
    output wire [PTR_W-1:0] ptr_o,
    output wire [LAT_W-1:0] lat_o
);
    reg  [PTR_W-1:0] ptr_ff;
    reg  [LAT_W-1:0] lat_ff;
    reg  [PTR_W-1:0] nxt_ptr;
    wire [PTR_W-1:0] ptr_inc = ptr_ff + {{(PTR_W-1){1'b0}}, 1'b1};
    wire [PTR_W-1:0] ptr_dec = ptr_ff - {{(PTR_W-1){1'b0}}, 1'b1};

    // pre-increment uses bumped pointer
    assign access_addr_o = (mode_i == `OFD_TM_PREINC) ? ptr_inc : ptr_ff;
    assign ptr_o         = ptr_ff;
    assign lat_o         = lat_ff;

    // pointer update per mode
    always @* begin
        nxt_ptr = ptr_ff;
        if (op_i) begin
            case (mode_i)
                `OFD_TM_POSTINC: nxt_ptr = ptr_inc;
                `OFD_TM_POSTDEC: nxt_ptr = ptr_dec;
                `OFD_TM_PREINC:  nxt_ptr = ptr_inc;
                default:         nxt_ptr = ptr_ff;
            endcase
        end else if (sw_ptr_we_i) begin
            nxt_ptr = sw_ptr_i;
        end
    end

    // pointer and latch, hardware wins
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ptr_ff <= `OFD_RST_TPTR;
            lat_ff <= `OFD_RST_TLAT;
        end else begin
            ptr_ff <= nxt_ptr;
            if (op_i && !op_wr_i) begin
                lat_ff <= pm_rdata_i;
            end else if (sw_lat_we_i) begin
                lat_ff <= sw_lat_i;
            end
        end
    end
endmodule
`default_nettype wire

// File: hdl/ofd_shadow.v
// fast call and return shadow registers
`timescale 1ns/1ps
`default_nettype none
module ofd_shadow #(
    parameter BANK_W = 4
) (
    // clock and reset
    input  wire              clk_i,
    input  wire              sys_rst_i,
    // save request and live values
    input  wire              save_i,
    input  wire [7:0]        work_i,
    input  wire [7:0]        status_i,
    input  wire [BANK_W-1:0] bank_i,
    // shadow contents
    output wire [7:0]        work_o,
    output wire [7:0]        status_o,
    output wire [BANK_W-1:0] bank_o
);
    reg [7:0]        work_ff;
    reg [7:0]        status_ff;
    reg [BANK_W-1:0] bank_ff;

    assign work_o   = work_ff;
    assign status_o = status_ff;
    assign bank_o   = bank_ff;

    // capture only on a fast-mode call
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            work_ff   <= 8'h00;
            status_ff <= 8'h00;
            bank_ff   <= {BANK_W{1'b0}};
        end else if (save_i) begin
            work_ff   <= work_i;
            status_ff <= status_i;
            bank_ff   <= bank_i;
        end
    end
endmodule
`default_nettype wire

// File: hdl/ofd_unused_placeholder_none.v
// no modules here
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: sim/ofd_fetch_model.sv
// fetch stage model presenting instruction words to the decoder
`timescale 1ns/1ps
`default_nettype none
module ofd_fetch_model (
    // clock
    input  wire logic       clk_i,
    // instruction words
    output var logic        valid_o,
    output var logic [15:0] word_o,
    output var logic [15:0] word2_o
);
    // idle after reset
    initial {valid_o, word_o, word2_o} = 33'h0;
    // present both words
    task automatic put(input logic [15:0] a, input logic [15:0] b);
        @(posedge clk_i);
        valid_o <= 1'b1;
        word_o <= a;
        word2_o <= b;
    endtask
    // released words show the inverse
    task automatic drop();
        @(posedge clk_i);
        valid_o <= 1'b0;
        word_o <= ~word_o;
        word2_o <= ~word2_o;
    endtask
endmodule
`default_nettype wire

// File: sim/ofd_top_asserts.sv
// port assertions for the operand field decoder
`timescale 1ns/1ps
`default_nettype none
module ofd_top_asserts #(
    parameter BANK_W = 4,
    parameter PTR_W  = 21
) (
    // clock and reset
    input wire logic              clk_i,
    input wire logic              sys_rst_i,
    // instruction and datapath
    input wire logic              instr_valid_i,
    input wire logic [15:0]       instr_i,
    input wire logic [15:0]       instr2_i,
    input wire logic [7:0]        alu_result_i,
    input wire logic [7:0]        file_rdata_i,
    // decoded fields and state
    input wire logic [11:0]       file_addr_o,
    input wire logic              file_we_o,
    input wire logic              work_we_o,
    input wire logic [7:0]        bit_mask_o,
    input wire logic [11:0]       src_addr_o,
    input wire logic [11:0]       dst_addr_o,
    input wire logic [20:0]       rel_offset_o,
    input wire logic [7:0]        working_register_o,
    input wire logic [BANK_W-1:0] bank_select_register_o,
    input wire logic [7:0]        product_high_byte_o,
    input wire logic [7:0]        product_low_byte_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // add to work, and multiply
    sequence s_wr_work; instr_valid_i && instr_i[15:9] == 7'h12; endsequence
    sequence s_mul; instr_valid_i && instr_i[15:9] == 7'h01; endsequence
    property p_bank; instr_i[15:10] == 6'h09 && instr_i[8]
        |-> file_addr_o == {bank_select_register_o, instr_i[7:0]}; endproperty
    a_bank: assert property (p_bank) else $error("banked address wrong");
    property p_access; instr_i[15:10] == 6'h09 && !instr_i[8] |-> file_addr_o ==
        (instr_i[7:0] < 8'h60 ? {4'h0, instr_i[7:0]} : {4'hf, instr_i[7:0]}); endproperty
    a_access: assert property (p_access) else $error("access address wrong");
    property p_dest; instr_valid_i && instr_i[15:10] == 6'h09
        |-> file_we_o == instr_i[9] && work_we_o == !instr_i[9]; endproperty
    a_dest: assert property (p_dest) else $error("destination wrong");
    property p_work; s_wr_work |=> working_register_o == $past(alu_result_i); endproperty
    a_work: assert property (p_work) else $error("work not written");
    property p_mask; instr_i[15:12] == 4'h8 |-> bit_mask_o == 8'h01 << instr_i[11:9]; endproperty
    a_mask: assert property (p_mask) else $error("bit mask wrong");
    property p_move; instr_i[15:12] == 4'hc
        |-> src_addr_o == instr_i[11:0] && dst_addr_o == instr2_i[11:0]; endproperty
    a_move: assert property (p_move) else $error("move addresses wrong");
    property p_rel; instr_i[15:11] == 5'h1a
        |-> rel_offset_o == {{10{instr_i[10]}}, instr_i[10:0]}; endproperty
    a_rel: assert property (p_rel) else $error("offset wrong");
    property p_prod; s_mul |=> {product_high_byte_o, product_low_byte_o} ==
        $past(working_register_o) * $past(file_rdata_i); endproperty
    a_prod: assert property (p_prod) else $error("product wrong");
endmodule
bind ofd_top ofd_top_asserts #(.BANK_W(BANK_W), .PTR_W(PTR_W)) i_chk (.*);
`default_nettype wire

// File: sim/operand_field_decoder_tb.sv
// self-checking bench for the operand field decoder
`timescale 1ns/1ps
`default_nettype none
module operand_field_decoder_tb;
    logic clk_i = 1'b0, sys_rst_i = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] alu_result_i = 8'h0, file_rdata_i = 8'h0, status_i = 8'h0, pm_rdata_i = 8'h0;
    logic [11:0] index_ptr_i = 12'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire instr_valid_i, dest_is_file_o, file_we_o, work_we_o, is_relative_o, fast_o;
    wire two_word_o, pm_rd_o, pm_wr_o, status_restore_o;
    wire [15:0] instr_i, instr2_i;
    wire [11:0] file_addr_o, src_addr_o, dst_addr_o, lit12_o;
    wire [7:0] file8_o, bit_mask_o, lit8_o, pm_wdata_o, status_shadow_o, working_register_o;
    wire [7:0] product_high_byte_o, product_low_byte_o;
    wire [3:0] bank_select_register_o;
    wire [2:0] bit_index_o;
    wire [1:0] indirect_pointer_select_o;
    wire [19:0] lit20_o, direct_addr_o;
    wire [20:0] rel_offset_o, pm_addr_o;
    integer miscompares = 0, n_tests = 0, cyc = 0;
    always #5 clk_i = ~clk_i;
    ofd_fetch_model i_fetch (.clk_i, .valid_o(instr_valid_i), .word_o(instr_i), .word2_o(instr2_i));
    ofd_top i_dut (.*);
    // compare and count
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // bus write
    task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", er, s_axi_bresp);
    endtask
    // bus read and compare
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
    endtask
    // issue, then retire
    task automatic run(input logic [15:0] a, input logic [15:0] b, input logic [7:0] d);
        i_fetch.put(a, b);
        alu_result_i <= d;
        file_rdata_i <= d;
        pm_rdata_i <= d;
        status_i <= d;
        #1;
    endtask
    task automatic fin();
        i_fetch.drop();
        #1;
    endtask
    // register map
    task automatic t_regs();
        for (int i = 0; i < 5; i++) rchk(8'(i * 4), 32'h0, 2'h0);
        wchk(8'h00, 32'hffff_fff5, 2'h0);
        rchk(8'h00, 32'h5, 2'h0);
        wchk(8'h08, 32'hffff_ffff, 2'h0);
        rchk(8'h08, 32'h1f_ffff, 2'h0);
        wchk(8'h0c, 32'hffff_ffff, 2'h0);
        rchk(8'h0c, 32'hff, 2'h0);
        wchk(8'h10, 32'h1, 2'h2);
        wchk(8'h18, 32'h1, 2'h2);
        rchk(8'h18, 32'h0, 2'h2);
    endtask
    // byte format
    task automatic t_byte();
        run(16'h2734, 16'h0, 8'h11);
        chk("fa_bank", 12'h534, file_addr_o);
        chk("file_we", 1'b1, file_we_o);
        chk("dfile", 1'b1, dest_is_file_o);
        chk("work_we", 1'b0, work_we_o);
        fin();
        run(16'h2434, 16'h0, 8'h5a);
        chk("fa_acc", 12'h034, file_addr_o);
        chk("work_we0", 1'b1, work_we_o);
        fin();
        chk("work", 8'h5a, working_register_o);
        run(16'h2480, 16'h0, 8'h0);
        chk("fa_hi", 12'hf80, file_addr_o);
        fin();
    endtask
    // every bit index
    task automatic t_bit();
        for (int b = 0; b < 8; b++) begin
            run(16'h8112 | 16'(b << 9), 16'h0, 8'h0);
            chk("mask", 8'h01 << b, bit_mask_o);
            chk("bidx", b, bit_index_o);
            chk("fa_bit", 12'h512, file_addr_o);
            fin();
        end
    endtask
    // other fields
    task automatic t_fields();
        run(16'hc123, 16'hf456, 8'h0);
        chk("src", 12'h123, src_addr_o);
        chk("dst", 12'h456, dst_addr_o);
        chk("two", 1'b1, two_word_o);
        fin();
        run(16'hee2a, 16'hf0bc, 8'h0);
        chk("ptrsel", 2'h2, indirect_pointer_select_o);
        chk("lit12", 12'habc, lit12_o);
        fin();
        run(16'hef56, 16'hf123, 8'h0);
        chk("lit20", 20'h12356, lit20_o);
        chk("direct", 20'h12356, direct_addr_o);
        fin();
        run(16'h0e7f, 16'h0, 8'h0);
        chk("lit8", 8'h7f, lit8_o);
        fin();
        run(16'hd7ff, 16'h0, 8'h0);
        chk("rel11", 21'h1f_ffff, rel_offset_o);
        chk("isrel", 1'b1, is_relative_o);
        fin();
        run(16'he0fe, 16'h0, 8'h0);
        chk("rel8", 21'h1f_fffe, rel_offset_o);
        fin();
    endtask
    // table modes
    task automatic t_table();
        for (int m = 0; m < 4; m++) begin
            wchk(8'h08, 32'h100, 2'h0);
            run(16'h0008 | 16'(m), 16'h0, 8'ha5);
            chk("pm_rd", 1'b1, pm_rd_o);
            chk("pm_addr", m == 3 ? 32'h101 : 32'h100, pm_addr_o);
            fin();
            rchk(8'h08, m == 2 ? 32'hff : (m == 0 ? 32'h100 : 32'h101), 2'h0);
            rchk(8'h0c, 32'ha5, 2'h0);
        end
        run(16'h000c, 16'h0, 8'h0);
        chk("pm_wr", 1'b1, pm_wr_o);
        chk("pm_wdata", 8'ha5, pm_wdata_o);
        fin();
    endtask
    // multiply and fast mode
    task automatic t_mul_fast();
        wchk(8'h04, 32'h12, 2'h0);
        run(16'h0220, 16'h0, 8'h34);
        fin();
        chk("product_high_byte", 8'h03, product_high_byte_o);
        chk("product_low_byte", 8'ha8, product_low_byte_o);
        run(16'hed00, 16'hf000, 8'h3c);
        chk("fast1", 1'b1, fast_o);
        fin();
        run(16'hec00, 16'hf000, 8'h77);
        chk("fast0", 1'b0, fast_o);
        fin();
        chk("shadow", 8'h3c, status_shadow_o);
        wchk(8'h04, 32'h99, 2'h0);
        run(16'h0013, 16'h0, 8'h0);
        chk("restore", 1'b1, status_restore_o);
        fin();
        chk("work_back", 8'h12, working_register_o);
    endtask
    task automatic print_verdict();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_regs();
        t_byte();
        t_bit();
        t_fields();
        t_table();
        t_mul_fast();
        print_verdict();
    end
endmodule
`default_nettype wire
